// ===== dv/eic_assertions.sv
// Port checks for the index event block: bus handshakes and the decimal flag.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/10ps
module eic_assertions
  import eic_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic decimal_constant,
  input wire logic index_event
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == EIC_RESP_SLVERR |->
    s_axi_rdata == EIC_ZERO) else $error("error read not zero");
  a_decimal_follow: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_awaddr == EIC_ADDR_CONFIG && s_axi_wvalid && s_axi_wready |->
    ##3 decimal_constant == $past(s_axi_wdata[0], 3)) else $error("decimal flag wrong");
  c_event: cover property (index_event);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == EIC_RESP_SLVERR);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind eic_index_event eic_assertions chk_u (.*);

// ===== dv/eic_encoder_model.sv
// Quadrature encoder with an index line high at count zero only.
// Assumes the bench requests single steps, one at a time.
`timescale 1ns/10ps
module eic_encoder_model (
  // Clock.
  input wire logic aclk,
  // Motion requests.
  input wire logic step_req,
  input wire logic step_dir,
  // Encoder lines and step pulses.
  output logic enc_a,
  output logic enc_b,
  output logic enc_n,
  output logic enc_step_valid,
  output logic enc_step_up
);
  int pos_ff = 2;
  // Moves one count per request and reports it as a step pulse.
  always_ff @(posedge aclk) begin
    enc_step_valid <= step_req;
    enc_step_up <= step_dir;
    if (step_req) pos_ff <= step_dir ? pos_ff + 1 : pos_ff - 1;
  end
  // Gray order of A and B, so only one line changes per count.
  assign enc_a = pos_ff[1] ^ pos_ff[0];
  assign enc_b = pos_ff[1];
  assign enc_n = (pos_ff == 0);
endmodule

// ===== dv/encoder_index_event_config_tb.sv
// Self-checking bench for the index event block with an encoder model.
// Assumes the model drives the encoder lines; the bus master lives here.
`timescale 1ns/10ps
module encoder_index_event_config_tb
  import eic_pkg::*;
;
  logic aclk = 0, aresetn = 0, step_req = 0, step_dir = 0;
  logic enc_a, enc_b, enc_n, enc_step_valid, enc_step_up, index_event, decimal_constant;
  logic [31:0] actual_step_position = 32'h0000_00AA, s_axi_wdata = 0, s_axi_rdata, rd_q;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
  int num_errors = 0, comparisons = 0, ev_cnt;
  eic_index_event dut_u (.*);
  eic_encoder_model enc_u (.*);
  // Clock.
  always #50 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    resp_q = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
  endtask
  // One encoder count, then three more cycles, counting index pulses.
  task automatic move(input logic dir);
    step_req <= 1'b1;
    step_dir <= dir;
    repeat (4) begin
      @(posedge aclk);
      step_req <= 1'b0;
      ev_cnt += index_event;
    end
  endtask
  // Reset value, refused places and the decimal flag.
  task automatic t_regs();
    rd(EIC_ADDR_CONFIG);
    chk(rd_q, EIC_CONFIG_RESET);
    rd(8'hFC);
    chk(rd_q, EIC_ZERO);
    chk(resp_q, EIC_RESP_SLVERR);
    wr(EIC_ADDR_ENC_POS, 32'h0000_0001);
    chk(resp_q, EIC_RESP_SLVERR);
    wr(EIC_ADDR_CONFIG, 32'h0000_0401);
    repeat (3) @(posedge aclk);
    chk(decimal_constant, 32'h0000_0001);
  endtask
  // Continuous clear with both latches on a rising index; no closed loop runs here.
  task automatic t_cont();
    wr(EIC_ADDR_ENC_RESET, 32'h1234_5678);
    wr(EIC_ADDR_CONFIG, 32'h0000_0C36);
    move(1'b0);
    move(1'b0);
    repeat (6) @(posedge aclk);
    rd(EIC_ADDR_ENC_POS);
    chk(rd_q, 32'h1234_5678);
    rd(EIC_ADDR_ENC_LATCH);
    chk(rd_q, 32'hFFFF_FFFE);
    rd(EIC_ADDR_POS_LATCH);
    chk(rd_q, 32'h0000_00AA);
  endtask
  // Single-shot clear on either index edge (the falling one comes first), self-clear, then no action.
  task automatic t_once();
    wr(EIC_ADDR_CONFIG, 32'h0000_027A);
    move(1'b1);
    repeat (6) @(posedge aclk);
    rd(EIC_ADDR_CONFIG);
    chk(rd_q, 32'h0000_0272);
    move(1'b0);
    repeat (6) @(posedge aclk);
    rd(EIC_ADDR_ENC_POS);
    chk(rd_q, 32'h1234_5677);
    move(1'b1);
  endtask
  // Sensitivity, polarity and A/B qualification over two index passes.
  task automatic t_table();
    logic [31:0] cfg [10] = '{32'h214, 32'h234, 32'h254, 32'h274, 32'h034, 32'h0B4,
      32'h134, 32'h2B4, 32'h224, 32'h210};
    int exp [10] = '{8, 2, 2, 4, 2, 0, 0, 2, 2, 0};
    for (int i = 0; i < 10; i++) begin
      wr(EIC_ADDR_CONFIG, cfg[i]);
      repeat (6) @(posedge aclk);
      ev_cnt = 0;
      move(1'b0);
      move(1'b0);
      move(1'b1);
      move(1'b1);
      // The last change shows up four edges later, so keep counting here.
      repeat (6) begin
        @(posedge aclk);
        ev_cnt += index_event;
      end
      chk(ev_cnt, exp[i]);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence after a four-cycle reset.
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_cont();
    t_once();
    t_table();
    tally_and_finish();
  end
  // Watchdog against a hung handshake.
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    tally_and_finish();
  end
endmodule

// ===== verilog/eic_index_event.sv
// Index event qualification, encoder position clear and latching, with an AXI4-Lite slave.
// Assumes A, B and N arrive synchronous to aclk; a quadrature counter outside supplies steps.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
module eic_index_event
  import eic_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Encoder lines.
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  // Position inputs.
  input wire logic enc_step_valid,
  input wire logic enc_step_up,
  input wire logic [31:0] actual_step_position,
  // Status outputs.
  output logic index_event,
  output logic decimal_constant,
  // AXI4-Lite write address.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [31:0] config_ff;
  logic [31:0] enc_pos_ff;
  logic [31:0] enc_reset_ff;
  logic [31:0] enc_latch_ff;
  logic [31:0] pos_latch_ff;
  eic_lines_s sync1_ff;
  eic_lines_s sync2_ff;
  logic n_prev_ff;
  logic index_event_ff;
  logic n_active;
  logic n_prev_active;
  logic edge_hit;
  logic ab_ok;
  logic qualified;
  logic fire;
  logic fire_once;
  logic [7:0] awaddr_ff;
  logic aw_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_held_ff;
  logic wr_go;
  logic cfg_wr;
  logic reset_wr;
  logic [31:0] cfg_merged;
  logic [31:0] reset_merged;
  logic [31:0] strb_mask;

  // Two-stage synchroniser for the encoder lines.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      n_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= '{a: enc_a, b: enc_b, n: enc_n};
      sync2_ff <= sync1_ff;
      n_prev_ff <= sync2_ff.n;
    end
  end

  // Polarity maps the raw index into its active sense.
  assign n_active = sync2_ff.n ~^ config_ff[EIC_BIT_POL];
  assign n_prev_active = n_prev_ff ~^ config_ff[EIC_BIT_POL];

  // Detection mode chosen by the sensitivity field.
  always_comb begin
    unique case (config_ff[EIC_SENS_LO +: 2])
      EIC_SENS_LEVEL: edge_hit = n_active;
      EIC_SENS_RISE: edge_hit = n_active & ~n_prev_active;
      EIC_SENS_FALL: edge_hit = ~n_active & n_prev_active;
      EIC_SENS_BOTH: edge_hit = n_active ^ n_prev_active;
    endcase
  end

  // A and B must sit at their qualifier levels unless the check is skipped.
  assign ab_ok = config_ff[EIC_BIT_SKIP_AB] |
                 ((sync2_ff.a == config_ff[EIC_BIT_POL_A]) &&
                  (sync2_ff.b == config_ff[EIC_BIT_POL_B]));
  assign qualified = edge_hit & ab_ok;
  assign fire_once = qualified & config_ff[EIC_BIT_ONCE];
  assign fire = qualified & (config_ff[EIC_BIT_CONT] | config_ff[EIC_BIT_ONCE]);

  // Byte-lane merge for register writes.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      strb_mask[i*8 +: 8] = {8{wstrb_ff[i]}};
    end
  end
  assign wr_go = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  assign cfg_wr = wr_go && (awaddr_ff == EIC_ADDR_CONFIG);
  assign reset_wr = wr_go && (awaddr_ff == EIC_ADDR_ENC_RESET);
  assign cfg_merged = (config_ff & ~strb_mask) | (wdata_ff & strb_mask);
  assign reset_merged = (enc_reset_ff & ~strb_mask) | (wdata_ff & strb_mask);

  // Configuration register; the single-shot bit self-clears after its event.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_ff <= EIC_CONFIG_RESET;
    end else if (cfg_wr) begin
      config_ff <= cfg_merged;
      if (fire_once) begin
        config_ff[EIC_BIT_ONCE] <= 1'b0;
      end
    end else if (fire_once) begin
      config_ff[EIC_BIT_ONCE] <= 1'b0;
    end
  end

  // Encoder reset value register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enc_reset_ff <= EIC_ZERO;
    end else if (reset_wr) begin
      enc_reset_ff <= reset_merged;
    end
  end

  // Encoder position counter; an index clear overrides counting.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enc_pos_ff <= EIC_ZERO;
    end else if (fire && config_ff[EIC_BIT_CLEAR]) begin
      enc_pos_ff <= enc_reset_ff;
    end else if (enc_step_valid) begin
      enc_pos_ff <= enc_step_up ? enc_pos_ff + 32'h0000_0001 : enc_pos_ff - 32'h0000_0001;
    end
  end

  // Latches capture the values present in the event cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enc_latch_ff <= EIC_ZERO;
      pos_latch_ff <= EIC_ZERO;
    end else begin
      if (fire && config_ff[EIC_BIT_LATCH_ENC]) begin
        enc_latch_ff <= enc_pos_ff;
      end
      if (fire && config_ff[EIC_BIT_LATCH_X]) begin
        pos_latch_ff <= actual_step_position;
      end
    end
  end

  // Registered event pulse, one cycle per acted event.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_event_ff <= 1'b0;
    end else begin
      index_event_ff <= fire;
    end
  end
  assign index_event = index_event_ff;
  assign decimal_constant = config_ff[EIC_BIT_DECIMAL];

  // Write address and data are held independently until both are present.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= EIC_ZERO;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_held_ff & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_ff & ~s_axi_bvalid;

  // Write response; unmapped or read-only addresses answer SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= EIC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (cfg_wr || reset_wr) ? EIC_RESP_OKAY : EIC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one read at a time, answered the cycle after acceptance.
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= EIC_ZERO;
      s_axi_rresp <= EIC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= EIC_RESP_OKAY;
      unique case (s_axi_araddr)
        EIC_ADDR_CONFIG: s_axi_rdata <= config_ff;
        EIC_ADDR_ENC_POS: s_axi_rdata <= enc_pos_ff;
        EIC_ADDR_ENC_RESET: s_axi_rdata <= enc_reset_ff;
        EIC_ADDR_ENC_LATCH: s_axi_rdata <= enc_latch_ff;
        EIC_ADDR_POS_LATCH: s_axi_rdata <= pos_latch_ff;
        EIC_ADDR_STATUS: s_axi_rdata <= {29'h0000_0000, sync2_ff.a, sync2_ff.b, sync2_ff.n};
        default: begin
          s_axi_rdata <= EIC_ZERO;
          s_axi_rresp <= EIC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== verilog/eic_pkg.sv
// Constants and carrier types for the encoder index event configuration block.
// Assumes a single 10 MHz clock and an AXI4-Lite master with 32-bit data.
package eic_pkg;

  // Register byte addresses; printed offsets are indices, four bytes apart.
  localparam logic [7:0] EIC_IDX_CONFIG = 8'h07;
  localparam logic [7:0] EIC_ADDR_CONFIG = 8'h1C;
  localparam logic [7:0] EIC_ADDR_ENC_POS = 8'h80;
  localparam logic [7:0] EIC_ADDR_ENC_RESET = 8'h84;
  localparam logic [7:0] EIC_ADDR_ENC_LATCH = 8'h88;
  localparam logic [7:0] EIC_ADDR_POS_LATCH = 8'h8C;
  localparam logic [7:0] EIC_ADDR_STATUS = 8'h90;

  // Reset values.
  localparam logic [31:0] EIC_CONFIG_RESET = 32'h0000_0400;
  localparam logic [31:0] EIC_ZERO = 32'h0000_0000;

  // Field positions in the configuration register.
  localparam int EIC_BIT_DECIMAL = 0;
  localparam int EIC_BIT_CLEAR = 1;
  localparam int EIC_BIT_CONT = 2;
  localparam int EIC_BIT_ONCE = 3;
  localparam int EIC_BIT_POL = 4;
  localparam int EIC_SENS_LO = 5;
  localparam int EIC_BIT_POL_A = 7;
  localparam int EIC_BIT_POL_B = 8;
  localparam int EIC_BIT_SKIP_AB = 9;
  localparam int EIC_BIT_LATCH_ENC = 10;
  localparam int EIC_BIT_LATCH_X = 11;

  // Index sensitivity codes.
  localparam logic [1:0] EIC_SENS_LEVEL = 2'h0;
  localparam logic [1:0] EIC_SENS_RISE = 2'h1;
  localparam logic [1:0] EIC_SENS_FALL = 2'h2;
  localparam logic [1:0] EIC_SENS_BOTH = 2'h3;

  // AXI4-Lite responses.
  localparam logic [1:0] EIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] EIC_RESP_SLVERR = 2'h2;

  // Synchronised encoder lines.
  typedef struct packed {
    logic a;
    logic b;
    logic n;
  } eic_lines_s;

endpackage
